// file: verilog/dwl_core.sv
`timescale 1ns/100ps
`include "dwl_regs.svh"
// ==========================================================
// write leveling engine of the dram device
module dwl_core #(
  parameter int LANES     = 2,                    // byte lanes, two on x16
  parameter bit PRIME_ALL = 1'b0                  // 1: feedback on all bits
) (
  input  wire logic            clk_i,             // device clock, 125 MHz
  input  wire logic            reset_n_i,         // synchronous reset, low
  input  wire dwl_pkg::dwl_mrs_t mrs_i,           // mode register write
  input  wire logic            term_ctl_i,        // termination control pin
  input  wire logic            ck_i,              // memory clock pin level
  input  wire logic [LANES-1:0] strobe_i,         // lane strobes, true side
  output logic                 level_mode_o,      // leveling mode active
  output logic                 qoff_o,            // output buffer disabled
  output logic [LANES-1:0]     strobe_term_o,     // strobe pair termination on
  output logic                 dq_term_o,         // data line termination on
  output logic [LANES-1:0]     read_strobe_oe_o,  // read strobe drive enable
  output logic [LANES*8-1:0]   dq_o,              // data pin output
  output logic [LANES*8-1:0]   dq_oe_o,           // data pin drive enable
  output logic [15:0]          mr1_o              // first mode register image
);
  import dwl_pkg::*;

  localparam int DLY = `DWL_WLO_CYC + `DWL_WLOE_CYC;

  // ==========================================================
  // pin synchronisers
  logic [LANES-1:0] stb_s1_q, stb_s2_q, stb_s3_q;
  logic             ck_s1_q, ck_s2_q, term_s1_q, term_s2_q;

  // two flops on every asynchronous pin, third stage for edges
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stb_s1_q <= '0;
      stb_s2_q <= '0;
      stb_s3_q <= '0;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      term_s1_q <= 1'b0;
      term_s2_q <= 1'b0;
    end else begin
      stb_s1_q <= strobe_i;
      stb_s2_q <= stb_s1_q;
      stb_s3_q <= stb_s2_q;
      ck_s1_q <= ck_i;
      ck_s2_q <= ck_s1_q;
      term_s1_q <= term_ctl_i;
      term_s2_q <= term_s1_q;
    end
  end

  // ==========================================================
  // first mode register
  logic [15:0] mr1_q, mr1_d;
  wire         mr1_wr  = mrs_i.valid && (mrs_i.sel == `DWL_MR1_SEL);
  wire         lvl_now = mr1_q[`DWL_MR1_LEVEL_BIT];
  wire         lvl_new = mrs_i.data[`DWL_MR1_LEVEL_BIT];
  // exit write keeps only allowed bits, stay write takes only the buffer bit, writes outside leveling taken whole
  wire  [15:0] exit_img = (mr1_q & ~`DWL_MR1_EXIT_MASK) | (mrs_i.data & `DWL_MR1_EXIT_MASK);
  wire  [15:0] qoff_img = {mrs_i.data[`DWL_MR1_QOFF_BIT], mr1_q[14:0]};
  wire  [15:0] stay_img = {mr1_q[15:13], qoff_img[15], mr1_q[11:0]};

  // write selection inside and outside leveling
  always_comb begin
    mr1_d = mr1_q;
    if (mr1_wr && !lvl_now) begin
      mr1_d = mrs_i.data;
    end else if (mr1_wr && !lvl_new) begin
      mr1_d = exit_img & ~(16'h0001 << `DWL_MR1_LEVEL_BIT);
    end else if (mr1_wr) begin
      mr1_d = stay_img;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mr1_q <= `DWL_MR1_RESET;
    end else begin
      mr1_q <= mr1_d;
    end
  end

  wire entering = !lvl_now && mr1_d[`DWL_MR1_LEVEL_BIT];

  // ==========================================================
  // per lane sampling and feedback
  logic [LANES*8-1:0] dq_d, dq_q, oe_d, oe_q;
  logic [LANES-1:0]   sterm_q;
  logic               qoff_q, lvl_q;
  logic               dq_term_q;
  logic [LANES-1:0]   rstb_q;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      dwl_state_t st_q;
      logic [DLY-1:0] pipe_q;
      logic [DLY-1:0] arm_q;
      wire            rise = stb_s2_q[g] && !stb_s3_q[g];
      wire            fb   = pipe_q[DLY-1];
      wire            shown = arm_q[DLY-1];
      wire            drive = !mr1_q[`DWL_MR1_QOFF_BIT];
      wire [7:0]      feed  = PRIME_ALL ? {8{fb}} : {7'h00, fb};

      // sample clock level on strobe rise, delay to the pins
      always_ff @(posedge clk_i) begin
        if (!reset_n_i || !lvl_now) begin
          pipe_q <= '0;
          arm_q <= '0;
          st_q <= DWL_IDLE;
        end else begin
          pipe_q <= {pipe_q[DLY-2:0], rise ? ck_s2_q : pipe_q[0]};
          arm_q <= {arm_q[DLY-2:0], arm_q[0] | rise};
          if (st_q == DWL_IDLE) begin
            st_q <= DWL_UNDEF;
          end else if (shown) begin
            st_q <= DWL_FEED;
          end
        end
      end

      // lane pins: undefined drive, then feedback, others low
      always_comb begin
        dq_d[g*8 +: 8] = dq_q[g*8 +: 8];
        oe_d[g*8 +: 8] = 8'h00;
        if (lvl_now && drive) begin
          case (st_q)
            DWL_FEED: begin
              dq_d[g*8 +: 8] = feed;
              oe_d[g*8 +: 8] = 8'hFF;
            end
            DWL_UNDEF: begin
              dq_d[g*8 +: 8] = 8'hA5;
              oe_d[g*8 +: 8] = 8'hFF;
            end
            default: begin
              oe_d[g*8 +: 8] = 8'h00;
            end
          endcase
        end
      end

      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          sterm_q[g] <= 1'b0;
        end else begin
          sterm_q[g] <= lvl_now && term_s2_q;
        end
      end
    end
  endgenerate

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dq_q <= '0;
      oe_q <= '0;
      qoff_q <= 1'b0;
      lvl_q <= 1'b0;
      dq_term_q <= 1'b0;
      rstb_q <= '0;
    end else begin
      dq_term_q <= 1'b0;
      rstb_q <= '0;
      dq_q <= dq_d;
      oe_q <= oe_d;
      qoff_q <= mr1_q[`DWL_MR1_QOFF_BIT];
      lvl_q <= lvl_now;
    end
  end

  assign level_mode_o     = lvl_q;
  assign qoff_o           = qoff_q;
  assign strobe_term_o    = sterm_q;
  assign dq_term_o        = dq_term_q;
  assign read_strobe_oe_o = rstb_q;
  assign dq_o             = dq_q;
  assign dq_oe_o          = oe_q;
  assign mr1_o            = mr1_q;

  // ==========================================================
  // checks
  a_entry_sets_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mr1_wr && lvl_new) |-> ##2 level_mode_o)
    else $error("leveling not entered");
  a_exit_clears_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mr1_wr && !lvl_new) |-> ##2 !level_mode_o)
    else $error("leveling not left");
  a_qoff_no_drive: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $past(mr1_q[`DWL_MR1_QOFF_BIT]) |-> dq_oe_o == '0)
    else $error("data driven while output buffer off");
  a_dq_term_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    level_mode_o |-> !dq_term_o)
    else $error("data termination on in leveling");
  a_strobe_term: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (lvl_now && term_s2_q) |=> strobe_term_o == {LANES{1'b1}})
    else $error("strobe termination not applied");
  a_exit_keeps_bits: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mr1_wr && lvl_now && !lvl_new) |=> mr1_q[`DWL_MR1_QOFF_BIT] == $past(mrs_i.data[`DWL_MR1_QOFF_BIT]))
    else $error("exit update lost");
  a_no_read_strobe: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    level_mode_o |-> read_strobe_oe_o == '0)
    else $error("read strobe driven");
  a_prime_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!PRIME_ALL && g_lane[0].st_q == DWL_FEED && dq_oe_o[0]) |=> dq_o[7:1] == 7'h00)
    else $error("non-prime bits not low");
  a_entry_undef: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    entering |=> g_lane[0].st_q == DWL_IDLE ##1 g_lane[0].st_q == DWL_UNDEF)
    else $error("entry state wrong");

  // mode flag and buffer flag track the register one cycle late
  a_level_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    level_mode_o == $past(lvl_now))
    else $error("level flag out of step");
  a_qoff_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    qoff_o == $past(mr1_q[`DWL_MR1_QOFF_BIT]))
    else $error("buffer flag out of step");

  // undefined drive pattern before the first sample
  a_undef_drive: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (g_lane[0].st_q == DWL_UNDEF && lvl_now && !mr1_q[`DWL_MR1_QOFF_BIT])
    |=> (dq_oe_o[7:0] == 8'hFF && dq_o[7:0] == 8'hA5))
    else $error("undefined drive missing");

  // captured clock level lands in the pipe on a strobe rise
  a_sample_take: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (lvl_now && g_lane[0].rise) |=> g_lane[0].pipe_q[0] == $past(ck_s2_q))
    else $error("clock level not sampled");

  // each lane shows its own delayed sample on its prime bit
  a_feed_lane0: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (g_lane[0].st_q == DWL_FEED && lvl_now && !mr1_q[`DWL_MR1_QOFF_BIT])
    |=> dq_o[0] == $past(g_lane[0].fb))
    else $error("lane 0 feedback wrong");
  a_feed_lane1: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (g_lane[1].st_q == DWL_FEED && lvl_now && !mr1_q[`DWL_MR1_QOFF_BIT])
    |=> dq_o[8] == $past(g_lane[1].fb))
    else $error("lane 1 feedback wrong");

  // strobe termination released outside leveling
  a_term_off_out: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !lvl_now |=> strobe_term_o == '0)
    else $error("strobe termination outside leveling");

  // a write that stays in leveling touches only the buffer bit
  a_stay_keeps: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mr1_wr && lvl_now && lvl_new) |=> mr1_q[11:0] == $past(mr1_q[11:0]))
    else $error("leveling write changed other bits");

  // the exit write carries every allowed bit
  a_exit_all_bits: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mr1_wr && lvl_now && !lvl_new)
    |=> (mr1_q & `DWL_MR1_EXIT_MASK) == ($past(mrs_i.data) & `DWL_MR1_EXIT_MASK))
    else $error("exit bits not taken");
endmodule // dwl_core

// file: verilog/dwl_regs.svh
`ifndef DWL_REGS_SVH
`define DWL_REGS_SVH
// first mode register bit positions
`define DWL_MR1_LEVEL_BIT   7
`define DWL_MR1_QOFF_BIT    12
// mode register address and reset image
`define DWL_MR1_SEL         3'h1
`define DWL_MR1_RESET       16'h0000
// first mode register bits that the leveling exit may also update
`define DWL_MR1_EXIT_MASK   16'h1266
// leveling output delay in ns and its cycle count at 8 ns
`define DWL_CLK_NS          8
`define DWL_WLO_NS          8
`define DWL_WLO_CYC         ((`DWL_WLO_NS + `DWL_CLK_NS - 1) / `DWL_CLK_NS)
// leveling output skew between bits, in cycles
`define DWL_WLOE_CYC        1
`endif

// file: verilog/dwl_pkg.sv
package dwl_pkg;
  // mode register write request
  typedef struct packed {
    logic        valid;
    logic [2:0]  sel;
    logic [15:0] data;
  } dwl_mrs_t;
  // data pin drive state, one byte lane
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } dwl_lane_t;
  typedef enum logic [1:0] {DWL_IDLE, DWL_UNDEF, DWL_FEED} dwl_state_t;
endpackage

// file: test/dwl_ctrl_model.sv
`timescale 1ns/100ps
`include "dwl_regs.svh"
// ==========================================================
// memory controller stand-in: clock, strobes, termination, mode writes
module dwl_ctrl_model (
  input  wire logic          clk_i,       // controller clock
  output dwl_pkg::dwl_mrs_t  mrs_o,       // mode register write
  output logic               term_ctl_o,  // termination control
  output logic               ck_o,        // memory clock, 80 ns period
  output logic [1:0]         strobe_o     // lane strobes, true side
);
  import dwl_pkg::*;
  // free running memory clock, phase unrelated to clk_i
  initial begin
    ck_o = 1'b0;
    #3;
    forever #40 ck_o = ~ck_o;
  end
  // idle levels, strobes parked low
  initial begin
    mrs_o = '0;
    term_ctl_o = 1'b0;
    strobe_o = 2'b00;
  end
  // one-cycle write; while leveling, callers send a buffer change or an exit write with random other bits
  task automatic mrs(input logic [15:0] d);
    @(posedge clk_i) #1 mrs_o = '{1'b1, `DWL_MR1_SEL, d};
    @(posedge clk_i) #1 mrs_o = '0;
  endtask
  // termination raised after the mode update, dropped before exit
  task automatic set_term(input logic v);
    @(posedge clk_i) #1 term_ctl_o = v;
  endtask
  // single strobe pulse, rising 16 ns after a ck edge and falling 40 ns later, ck level handed back
  task automatic pulse(input int lane, input bit rise, output logic lvl);
    if (rise) @(posedge ck_o);
    else @(negedge ck_o);
    #16 strobe_o[lane] = 1'b1;
    lvl = ck_o;
    #40 strobe_o[lane] = 1'b0;
  endtask
endmodule  // dwl_ctrl_model

// file: test/test_dwl_write_leveling.sv
`timescale 1ns/100ps
`include "dwl_regs.svh"
// ==========================================================
// write leveling bench against a reference image model
module test_dwl_write_leveling;
  import dwl_pkg::*;
  logic        clk_i;
  logic        reset_n_i;
  dwl_mrs_t    mrs;
  logic        term_ctl;
  logic        ck;
  logic [1:0]  strobe;
  logic        level_mode_o;
  logic        qoff_o;
  logic [1:0]  strobe_term_o;
  logic        dq_term_o;
  logic [1:0]  read_strobe_oe_o;
  logic [15:0] dq_o;
  logic [15:0] dq_oe_o;
  logic [15:0] mr1_o;
  logic [7:0]  lane_exp [2];
  logic        lvl;
  logic [15:0] d;
  int          fails = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          m = 0;
  dwl_ctrl_model ctrl_model_inst (.clk_i(clk_i), .mrs_o(mrs), .term_ctl_o(term_ctl), .ck_o(ck), .strobe_o(strobe));
  dwl_core #(.LANES(2), .PRIME_ALL(1'b0)) dwl_core_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .mrs_i(mrs), .term_ctl_i(term_ctl), .ck_i(ck), .strobe_i(strobe),
    .level_mode_o(level_mode_o), .qoff_o(qoff_o), .strobe_term_o(strobe_term_o), .dq_term_o(dq_term_o),
    .read_strobe_oe_o(read_strobe_oe_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .mr1_o(mr1_o));
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // mode write with reference image update, then image and mode checks
  task automatic wr(input logic [15:0] v);
    ctrl_model_inst.mrs(v);
    if (!m[7]) m = v;
    else if (!v[7]) m = ((m & ~`DWL_MR1_EXIT_MASK) | (v & `DWL_MR1_EXIT_MASK)) & ~32'h80;
    else m[12] = v[12];
    cyc(3);
    chk("mr1", mr1_o, m[15:0]);
    chk("level", {15'h0000, level_mode_o}, {15'h0000, m[7]});
    chk("qoff", {15'h0000, qoff_o}, {15'h0000, m[12]});
  endtask
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    reset_n_i = 1'b0;
    void'($urandom(32'h4352f7ed));
    lane_exp = '{8'hA5, 8'hA5};
    repeat (6) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    chk("mr1 reset", mr1_o, `DWL_MR1_RESET);
    chk("dq_oe reset", dq_oe_o, 16'h0000);
    $display("test reset done");
    d = 16'($urandom);
    d[7] = 1'b1;
    d[12] = 1'b0;
    d[9] = 1'b0;  // reference_resistor/4 nominal termination
    d[6] = 1'b0;
    d[2] = 1'b1;
    wr(d);
    chk("dq_oe undefined", dq_oe_o, 16'hFFFF);
    chk("dq undefined", dq_o, 16'hA5A5);
    ctrl_model_inst.set_term(1'b1);
    cyc(5);
    chk("strobe term on", {14'h0000, strobe_term_o}, 16'h0003);
    chk("dq term", {15'h0000, dq_term_o}, 16'h0000);
    $display("test entry done");
    // alternate lanes, ck low then high gives the 0 to 1 change on lane 0
    for (int i = 0; i < 4; i++) begin
      ctrl_model_inst.pulse(i % 2, i / 2, lvl);
      lane_exp[i % 2] = {7'h00, lvl};
      cyc(12);
      chk("feedback", dq_o, {lane_exp[1], lane_exp[0]});
      chk("read strobe", {14'h0000, read_strobe_oe_o}, 16'h0000);
    end
    $display("test feedback done");
    d = m[15:0];
    d[12] = 1'b1;
    wr(d);
    cyc(1);
    chk("dq_oe off", dq_oe_o, 16'h0000);
    ctrl_model_inst.set_term(1'b0);
    cyc(5);
    chk("strobe term off", {14'h0000, strobe_term_o}, 16'h0000);
    d = 16'($urandom);
    d[7] = 1'b0;
    wr(d);
    $display("test exit done");
    tally_and_finish();
  end
endmodule  // test_dwl_write_leveling
